// *** logic/ssr_ctl_end.sv ***
module ssr_ctl_end (
  input wire logic mclk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic cmd_valid, // Burst request offered.
  output logic cmd_ready, // Ready to take a burst request.
  input wire logic cmd_write, // High for a write burst.
  input wire logic [16:0] cmd_addr, // Starting word address.
  input wire logic [1:0] cmd_beats, // Beats in the burst minus one.
  input wire logic wr_valid, // Write word offered.
  output logic wr_ready, // Buffer has room for a word.
  input wire logic [31:0] wr_data, // Write word.
  input wire logic [3:0] wr_lanes_n, // Lanes to skip, active low enables.
  output logic rd_valid, // Read word pulse.
  output logic [31:0] rd_data, // Read word.
  input wire logic cfg_interleave, // High selects interleaved order.
  input wire logic sleep_want, // Ask the memory to sleep.
  output logic sleep_active, // Sleep request is raised.
  ssr_link_if.ctl_end link // Link to the memory.
);

  ssr_pkg::ssr_ctl_type state, next_state;
  logic [1:0] beats_left, next_beats_left;
  logic is_write, next_is_write;
  logic first, next_first;
  logic [16:0] addr_l, next_addr_l;
  logic [7:0] wake_cnt, next_wake_cnt;
  logic pres_rd, next_pres_rd;
  logic pres_wr, next_pres_wr;
  logic rd_expect, next_rd_expect;
  logic [31:0] stage, next_stage;
  logic next_cmd_ready, next_rd_valid, next_sleep;
  logic [31:0] next_rd_data;
  logic next_cg_n, next_cs_n, next_load_n, next_rw;
  logic [3:0] next_bw_n;
  logic [16:0] next_addr;
  logic [31:0] next_dq_out;
  logic next_dq_oe;
  logic [35:0] fifo_word;
  logic fifo_valid, fifo_pop;

  ////////////////////////////////////////////////////////////////////////
  // Write words wait here; the sequencer drains it only during write bursts.
  ssr_fifo #(.WIDTH(ssr_pkg::FIFO_W), .DEPTH(ssr_pkg::FIFO_DEPTH)) i_ssr_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data({wr_lanes_n, wr_data}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer. Idle cycles present a deselecting load, so the memory never
  // keeps stepping an old burst. A write beat lacking data gates the clock.
  always_comb begin
    next_state = state;
    next_beats_left = beats_left;
    next_is_write = is_write;
    next_first = first;
    next_addr_l = addr_l;
    next_wake_cnt = wake_cnt;
    next_cmd_ready = cmd_ready;
    next_sleep = link.sleep_request;
    next_cg_n = 1'h0;
    next_cs_n = 1'h1;
    next_load_n = 1'h0;
    next_rw = 1'h1;
    next_bw_n = ssr_pkg::LANES_OFF_N;
    next_addr = link.addr;
    next_pres_rd = 1'h0;
    next_pres_wr = 1'h0;
    next_stage = stage;
    fifo_pop = 1'h0;
    // A presented cycle counts only if its edge was not gated.
    next_dq_out = link.ctl_dq_out;
    next_dq_oe = link.ctl_dq_oe;
    next_rd_expect = 1'h0;
    if (!link.clock_gate_n) begin
      next_dq_out = stage; // R22
      next_dq_oe = pres_wr; // R22
      next_rd_expect = pres_rd;
    end
    next_rd_valid = rd_expect;
    next_rd_data = rd_expect ? link.dq_bus : rd_data;
    case (state)
      ssr_pkg::SSR_CTL_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          next_state = ssr_pkg::SSR_CTL_RUN;
          next_beats_left = cmd_beats;
          next_is_write = cmd_write;
          next_addr_l = cmd_addr;
          next_first = 1'h1;
          next_cmd_ready = 1'h0;
        end else if (sleep_want && !pres_rd && !pres_wr && !rd_expect && !link.ctl_dq_oe) begin
          next_state = ssr_pkg::SSR_CTL_SLEEP; // R18
          next_sleep = 1'h1; // R18
          next_cmd_ready = 1'h0;
        end
      end
      ssr_pkg::SSR_CTL_RUN: begin
        if (is_write && !fifo_valid) begin
          next_cg_n = 1'h1;
        end else begin
          next_cs_n = !first;
          next_load_n = !first;
          next_rw = !is_write;
          next_addr = addr_l;
          next_pres_rd = !is_write;
          next_pres_wr = is_write;
          next_bw_n = is_write ? fifo_word[35:32] : ssr_pkg::LANES_OFF_N;
          next_stage = fifo_word[31:0];
          fifo_pop = is_write;
          next_first = 1'h0;
          next_beats_left = 2'(beats_left - 2'h1);
          if (beats_left == 2'h0) begin
            next_state = ssr_pkg::SSR_CTL_IDLE;
            next_cmd_ready = 1'h1;
          end
        end
      end
      ssr_pkg::SSR_CTL_SLEEP: begin
        if (!sleep_want) begin
          next_sleep = 1'h0; // R21
          next_state = ssr_pkg::SSR_CTL_WAKE;
          next_wake_cnt = 8'(ssr_pkg::SLEEP_EXIT_CYCLES);
        end
      end
      ssr_pkg::SSR_CTL_WAKE: begin
        // Only deselects go out until recovery ends, so no write can slip in.
        next_wake_cnt = 8'(wake_cnt - 8'h1); // R19
        if (wake_cnt == 8'h1) begin
          next_state = ssr_pkg::SSR_CTL_IDLE;
          next_cmd_ready = 1'h1;
        end
      end
      default: begin
        next_state = ssr_pkg::SSR_CTL_IDLE;
        next_cmd_ready = 1'h1;
      end
    endcase
  end

  // Every link pin comes from a register; the enable stays low throughout.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= ssr_pkg::SSR_CTL_IDLE;
      beats_left <= 2'h0;
      is_write <= 1'h0;
      first <= 1'h0;
      addr_l <= '0;
      wake_cnt <= 8'h0;
      pres_rd <= 1'h0;
      pres_wr <= 1'h0;
      rd_expect <= 1'h0;
      stage <= '0;
      cmd_ready <= 1'h1;
      rd_valid <= 1'h0;
      rd_data <= '0;
      sleep_active <= 1'h0;
      link.sleep_request <= 1'h0; // R21
      link.clock_gate_n <= 1'h0;
      link.chip_select_first_n <= 1'h1;
      link.chip_select_second <= 1'h0;
      link.chip_select_third_n <= 1'h1;
      link.step_or_load_n <= 1'h0;
      link.read_write_n <= 1'h1;
      link.byte_lane_write_n <= ssr_pkg::LANES_OFF_N;
      link.output_enable_n <= 1'h0;
      link.burst_order_select <= 1'h1;
      link.addr <= '0;
      link.ctl_dq_out <= '0;
      link.ctl_dq_oe <= 1'h0;
    end else begin
      state <= next_state;
      beats_left <= next_beats_left;
      is_write <= next_is_write;
      first <= next_first;
      addr_l <= next_addr_l;
      wake_cnt <= next_wake_cnt;
      pres_rd <= next_pres_rd;
      pres_wr <= next_pres_wr;
      rd_expect <= next_rd_expect;
      stage <= next_stage;
      cmd_ready <= next_cmd_ready;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      sleep_active <= next_sleep;
      link.sleep_request <= next_sleep;
      link.clock_gate_n <= next_cg_n; // R2
      link.chip_select_first_n <= next_cs_n;
      link.chip_select_second <= !next_cs_n;
      link.chip_select_third_n <= next_cs_n;
      link.step_or_load_n <= next_load_n;
      link.read_write_n <= next_rw;
      link.byte_lane_write_n <= next_bw_n;
      link.output_enable_n <= 1'h0;
      link.burst_order_select <= cfg_interleave;
      link.addr <= next_addr;
      link.ctl_dq_out <= next_dq_out;
      link.ctl_dq_oe <= next_dq_oe;
    end
  end

endmodule

// *** logic/ssr_pkg.sv ***
package ssr_pkg;

  // Array shape of the x32 build: 131,072 words of four byte lanes.
  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int MEM_WORDS = 131072;
  localparam int BASE_W = ADDR_W - 2;

  // Depth of the write data buffer in the controller.
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = DATA_W + LANES;

  // Reset and idle values of the link controls.
  localparam logic [LANES-1:0] LANES_OFF_N = 4'hF;
  localparam logic [1:0] BEAT_FIRST = 2'h0;
  localparam logic [DATA_W-1:0] BUS_IDLE = 32'hFFFFFFFF;

  // Sleep recovery time; the figure is a plain default, not a part value.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLEEP_EXIT_NS = 100;
  localparam int SLEEP_EXIT_CYCLES = (SLEEP_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_W = 8;

  // Direction a burst was opened with.
  typedef enum logic [1:0] {SSR_BURST_NONE, SSR_BURST_READ, SSR_BURST_WRITE} ssr_burst_type;

  // Controller sequencing states.
  typedef enum logic [1:0] {SSR_CTL_IDLE, SSR_CTL_RUN, SSR_CTL_SLEEP, SSR_CTL_WAKE} ssr_ctl_type;

  // Low two address bits of a beat: interleaved XORs, linear counts modulo four.
  function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] beat,
                                           input logic interleaved);
    burst_low = interleaved ? (start ^ beat) : 2'(start + beat);
  endfunction

endpackage

// *** logic/ssr_link_if.sv ***
interface ssr_link_if;

  logic clock_gate_n; // High makes the memory skip the edge.
  logic chip_select_first_n; // Select, active low.
  logic chip_select_second; // Select, active high.
  logic chip_select_third_n; // Select, active low.
  logic step_or_load_n; // High steps the burst, low loads.
  logic read_write_n; // High read, low write, on loads.
  logic [3:0] byte_lane_write_n; // Per-lane write enables, active low.
  logic output_enable_n; // Asynchronous output enable, active low.
  logic burst_order_select; // High interleaved, low linear.
  logic sleep_request; // Asynchronous sleep, active high.
  logic [16:0] addr; // Word address.
  logic [31:0] ctl_dq_out; // Controller drive value.
  logic ctl_dq_oe; // Controller drives the data bus.
  logic [31:0] mem_dq_out; // Memory drive value.
  logic mem_dq_oe; // Memory drives the data bus.
  logic [31:0] dq_bus; // Resolved bus level.

  // Undriven bus reads as all ones, as if pulled up.
  assign dq_bus = mem_dq_oe ? mem_dq_out : (ctl_dq_oe ? ctl_dq_out : ssr_pkg::BUS_IDLE);

  modport ctl_end(
    output clock_gate_n, chip_select_first_n, chip_select_second, chip_select_third_n,
    output step_or_load_n, read_write_n, byte_lane_write_n, output_enable_n,
    output burst_order_select, sleep_request, addr, ctl_dq_out, ctl_dq_oe,
    input mem_dq_oe, dq_bus
  );

  modport mem_end(
    input clock_gate_n, chip_select_first_n, chip_select_second, chip_select_third_n,
    input step_or_load_n, read_write_n, byte_lane_write_n, output_enable_n,
    input burst_order_select, sleep_request, addr, ctl_dq_oe, dq_bus,
    output mem_dq_out, mem_dq_oe
  );

endinterface

// *** logic/ssr_fifo.sv ***
module ssr_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input wire logic mclk, // System clock.
  input wire logic srst, // Synchronous reset.
  input wire logic in_valid, // Word offered.
  output logic in_ready, // Room for a word.
  input wire logic [WIDTH-1:0] in_data, // Offered word.
  output logic out_valid, // Word available.
  input wire logic out_ready, // Word taken.
  output logic [WIDTH-1:0] out_data // Oldest word.
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////
  // Flags come from the count, so full and empty are never stale.
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = store[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and count arithmetic.
  always_comb begin
    next_wr_ptr = push ? AW'(wr_ptr + AW'(1)) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + AW'(1)) : rd_ptr;
    next_count = (AW+1)'(count + (AW+1)'(push) - (AW+1)'(pop));
  end

  // State registers.
  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage needs no reset; empty words are never read out.
  always_ff @(posedge mclk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

endmodule

// *** logic/ssr_mem_end.sv ***
// Operation
// R1: Synchronous inputs sampled on rising clock edge.
// R2: Clock gate high freezes address, burst, outputs.
// R3: New address captured on selected load only.
// R4: Selects sampled on loads; low, high, low.
// R5: Step counter when advancing, load when low.
// R6: Select read or write on selected load.
// R7: Each lane written only when its enable low.
// R8: Drive data only selected and enable low.
// R9: Output drivers off during writes.
// R10: Order select high gives interleaved XOR order.
// R11: Order select low gives linear count order.
// R12: Two-bit counter wraps every fourth beat.
// R13: Deselect load and following advances float bus.
// R14: Burst direction fixed by its load cycle.
// R15: Enable high dummy read; lanes high abort.
// R16: Gated cycle keeps read driving, no write.
// R17: Sleep deselects, keeps data, floats outputs.
// R18: Controller finishes operations before raising sleep.
// R19: After sleep only deselect or read cycles.
// R20: Data outputs float from power-up; here they float only from the first reset edge.
// R21: Unused sleep request tied low.
// R22: Write data taken one edge after command.
// R23: Read data one cycle after its edge.
// R24: Only two low bits step in a burst.
module ssr_mem_end (
  input wire logic mclk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  ssr_link_if.mem_end link, // Link to the controller.
  output logic asleep, // Memory is in sleep.
  output logic bursting // A read or write burst is open.
);

  ////////////////////////////////////////////////////////////////////////
  // Storage and burst state.
  logic [ssr_pkg::DATA_W-1:0] mem [0:ssr_pkg::MEM_WORDS-1];

  // Burst position.
  ssr_pkg::ssr_burst_type dir;
  logic [ssr_pkg::BASE_W-1:0] base;
  logic [1:0] start;
  logic [1:0] beat;

  // A late write waits here.
  logic wr_pend;
  logic [ssr_pkg::ADDR_W-1:0] wr_addr;
  logic [ssr_pkg::LANES-1:0] wr_lanes_n;

  // Read word and its drive.
  logic rd_drive;
  logic [ssr_pkg::DATA_W-1:0] rd_data;

  // Next values.
  ssr_pkg::ssr_burst_type next_dir;
  logic [ssr_pkg::BASE_W-1:0] next_base;
  logic [1:0] next_start;
  logic [1:0] next_beat;
  logic next_wr_pend;
  logic [ssr_pkg::ADDR_W-1:0] next_wr_addr;
  logic [ssr_pkg::LANES-1:0] next_wr_lanes_n;
  logic next_rd_drive;
  logic [ssr_pkg::DATA_W-1:0] next_rd_data;
  logic next_asleep;
  logic next_bursting;

  // Decodes of the current edge.
  logic edge_taken;
  logic selected;
  logic wr_fire;
  logic [ssr_pkg::ADDR_W-1:0] beat_addr;
  logic [ssr_pkg::DATA_W-1:0] array_word;

  ////////////////////////////////////////////////////////////////////////
  // Qualifiers of the current edge.
  assign edge_taken = !link.clock_gate_n && !link.sleep_request; // R2
  assign selected = !link.chip_select_first_n && link.chip_select_second
                    && !link.chip_select_third_n; // R4

  // A write captured on the previous taken edge lands on this one, with the
  // lanes sampled alongside its command; all lanes high leaves memory alone.
  // A gated edge leaves it pending.
  assign wr_fire = wr_pend && edge_taken; // R16

  ////////////////////////////////////////////////////////////////////////
  // Burst sequencing: load, step, deselect and the pending late write.
  always_comb begin
    next_dir = dir;
    next_base = base;
    next_start = start;
    next_beat = beat;
    next_wr_pend = wr_pend;
    next_wr_addr = wr_addr;
    next_wr_lanes_n = wr_lanes_n;
    next_rd_drive = rd_drive;
    next_rd_data = rd_data;
    next_asleep = link.sleep_request;
    next_bursting = bursting;

    beat_addr = {base, ssr_pkg::burst_low(start, beat, link.burst_order_select)};
    array_word = '0;

    if (link.sleep_request) begin
      // Sleep drops the burst and any unfinished write; stored words stay.
      next_dir = ssr_pkg::SSR_BURST_NONE; // R17
      next_wr_pend = 1'h0; // R17
      next_rd_drive = 1'h0; // R17
      next_bursting = 1'h0;
    end else if (!link.clock_gate_n) begin // R1
      // A taken edge loads, steps or deselects.
      if (!link.step_or_load_n) begin
        if (selected) begin
          // Upper bits are frozen here for the whole burst.
          next_base = link.addr[ssr_pkg::ADDR_W-1:2]; // R3 R24
          next_start = link.addr[1:0]; // R3
          next_beat = ssr_pkg::BEAT_FIRST; // R5
          next_dir = link.read_write_n ? ssr_pkg::SSR_BURST_READ
                                       : ssr_pkg::SSR_BURST_WRITE; // R6 R14
        end else begin
          // Any select off deselects.
          next_dir = ssr_pkg::SSR_BURST_NONE; // R13
        end
      end else if (dir != ssr_pkg::SSR_BURST_NONE) begin
        // Two-bit counter: the fifth beat is the starting address again.
        next_beat = 2'(beat + 2'h1); // R5 R12
      end

      beat_addr = {next_base, ssr_pkg::burst_low(next_start, next_beat,
                                                 link.burst_order_select)}; // R10 R11 R24

      // Write beats record address and lanes; data follows on the next taken edge.
      next_wr_pend = (next_dir == ssr_pkg::SSR_BURST_WRITE); // R14 R22
      next_wr_addr = beat_addr;
      next_wr_lanes_n = link.byte_lane_write_n; // R7 R15

      // Read data is fetched on the command edge, giving flow-through timing.
      // A write landing on this edge to the same word is forwarded so the
      // read sees it; without this a write-then-read returns the old word.
      array_word = mem[beat_addr];
      for (int i = 0; i < ssr_pkg::LANES; i++) begin
        if (wr_fire && (wr_addr == beat_addr) && !wr_lanes_n[i]) begin
          array_word[i*ssr_pkg::LANE_W +: ssr_pkg::LANE_W] =
            link.dq_bus[i*ssr_pkg::LANE_W +: ssr_pkg::LANE_W];
        end
      end

      next_rd_data = array_word; // R23
      next_rd_drive = (next_dir == ssr_pkg::SSR_BURST_READ); // R9 R13
      // Status for the system.
      next_bursting = (next_dir != ssr_pkg::SSR_BURST_NONE);
    end
  end

  // Burst registers; reset leaves the data drivers off.
  always_ff @(posedge mclk) begin
    if (srst) begin
      // Stored words survive reset.
      dir <= ssr_pkg::SSR_BURST_NONE;
      base <= '0;
      start <= ssr_pkg::BEAT_FIRST;
      beat <= ssr_pkg::BEAT_FIRST;

      wr_pend <= 1'h0;
      wr_addr <= '0;
      wr_lanes_n <= ssr_pkg::LANES_OFF_N;

      rd_drive <= 1'h0; // R20
      rd_data <= '0;
      asleep <= 1'h0;
      bursting <= 1'h0;
    end else begin
      dir <= next_dir;
      base <= next_base;
      start <= next_start;
      beat <= next_beat;

      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      wr_lanes_n <= next_wr_lanes_n;

      rd_drive <= next_rd_drive;
      rd_data <= next_rd_data;
      asleep <= next_asleep;
      bursting <= next_bursting;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Array write, each byte lane under its own enable, all on one edge, taken from the bus a cycle late.
  always_ff @(posedge mclk) begin
    if (wr_fire) begin
      for (int i = 0; i < ssr_pkg::LANES; i++) begin
        // A lane left high keeps its byte.
        if (!wr_lanes_n[i]) begin // R7 R15
          mem[wr_addr][i*ssr_pkg::LANE_W +: ssr_pkg::LANE_W] <=
            link.dq_bus[i*ssr_pkg::LANE_W +: ssr_pkg::LANE_W]; // R22
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output enable and sleep act without a clock, so the drive is gated
  // here rather than registered; a read beat with enable high is a dummy.
  // Limitation: the drive is unknown until the
  // first reset edge, so reset before use.
  assign link.mem_dq_out = rd_data;
  assign link.mem_dq_oe = rd_drive && !link.output_enable_n
                          && !link.sleep_request; // R8 R15 R16 R17

endmodule

// *** dv/ssr_link_sva.sv ***
// Watches the link between the two ends; each check ties a wire to its cause.
module ssr_link_sva (
  input wire logic mclk, // Clock.
  input wire logic srst, // Reset.
  input wire logic clock_gate_n, // Edge skip.
  input wire logic chip_select_first_n, // Select.
  input wire logic chip_select_second, // Select.
  input wire logic chip_select_third_n, // Select.
  input wire logic step_or_load_n, // Load low.
  input wire logic read_write_n, // Direction.
  input wire logic output_enable_n, // Enable.
  input wire logic sleep_request, // Sleep.
  input wire logic ctl_dq_oe, // Ctl drive.
  input wire logic mem_dq_oe, // Mem drive.
  input wire logic [31:0] mem_dq_out // Mem data.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic load;
  logic sel;
  // Gated and sleeping edges do nothing, so only taken loads count.
  assign load = !clock_gate_n && !sleep_request && !step_or_load_n;
  assign sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  a_drive_enable: assert property (mem_dq_oe |-> !output_enable_n && !sleep_request)
    else $error("bus driven while disabled");
  a_one_driver: assert property (!(mem_dq_oe && ctl_dq_oe))
    else $error("bus driven by both ends");
  a_read_flows: assert property (load && sel && read_write_n && !output_enable_n |=> mem_dq_oe)
    else $error("read data not driven");
  a_write_turns: assert property (load && sel && !read_write_n |=> !mem_dq_oe && ctl_dq_oe)
    else $error("write beat bus direction wrong");
  a_deselect_floats: assert property (load && !sel |=> !mem_dq_oe)
    else $error("deselected memory drives bus");
  a_gate_holds: assert property (
    clock_gate_n && !sleep_request |=> $stable(mem_dq_out) && $stable(mem_dq_oe))
    else $error("gated edge changed output");
  a_sleep_idle: assert property ($rose(sleep_request) |-> !$past(ctl_dq_oe) && !$past(mem_dq_oe))
    else $error("sleep raised with bus busy");
  a_wake_reads: assert property ($fell(sleep_request) |-> (!(load && sel && !read_write_n)) [*8])
    else $error("write during sleep recovery");
endmodule

// *** dv/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [16:0] cmd_addr = 17'h00000;
  logic [1:0] cmd_beats = 2'h0;
  logic wr_valid = 1'b0;
  logic [31:0] wr_data = 32'h00000000;
  logic [3:0] wr_lanes_n = 4'h0;
  logic cfg_interleave = 1'b1;
  logic sleep_want = 1'b0;
  logic cmd_ready, wr_ready, rd_valid, sleep_active, asleep, bursting;
  logic [31:0] rd_data;
  logic [31:0] model [int];
  logic [16:0] a;
  logic [1:0] b;
  logic il;
  int num_errors = 0;
  int comparisons = 0;
  ssr_link_if link ();
  ssr_ctl_end i_ssr_ctl_end (.mclk(mclk), .srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_beats(cmd_beats), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .wr_lanes_n(wr_lanes_n), .rd_valid(rd_valid), .rd_data(rd_data),
    .cfg_interleave(cfg_interleave), .sleep_want(sleep_want), .sleep_active(sleep_active), .link(link.ctl_end));
  ssr_mem_end i_ssr_mem_end (.mclk(mclk), .srst(srst), .link(link.mem_end), .asleep(asleep), .bursting(bursting));
  ssr_link_sva i_ssr_link_sva (.mclk(mclk), .srst(srst), .clock_gate_n(link.clock_gate_n),
    .chip_select_first_n(link.chip_select_first_n), .chip_select_second(link.chip_select_second),
    .chip_select_third_n(link.chip_select_third_n), .step_or_load_n(link.step_or_load_n),
    .read_write_n(link.read_write_n), .output_enable_n(link.output_enable_n), .sleep_request(link.sleep_request),
    .ctl_dq_oe(link.ctl_dq_oe), .mem_dq_oe(link.mem_dq_oe), .mem_dq_out(link.mem_dq_out));
  // Free-running 100 MHz clock.
  always #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Beat address: the upper bits stay, the low two step in the chosen order.
  function automatic logic [16:0] beat_addr(input int k);
    logic [1:0] s;
    s = k[1:0];
    return {a[16:2], il ? (a[1:0] ^ s) : (a[1:0] + s)};
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] ln);
    for (int i = 0; i < 4; i++) if (!ln[i]) old[8*i +: 8] = d[8*i +: 8];
    return old;
  endfunction
  // Each handshake task lowers its strobe and lets an edge pass, so calls never collide.
  task automatic push(input logic [31:0] d, input logic [3:0] ln);
    wr_valid <= 1'b1;
    wr_data <= d;
    wr_lanes_n <= ln;
    @(posedge mclk);
    for (int n = 0; n < 400 && !wr_ready; n++) @(posedge mclk);
    wr_valid <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic issue(input logic w);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_beats <= b;
    @(posedge mclk);
    for (int n = 0; n < 400 && !cmd_ready; n++) @(posedge mclk);
    cmd_valid <= 1'b0;
    @(posedge mclk);
  endtask
  // Wait for the burst to end; the order select must not move under a live burst.
  task automatic settle();
    for (int n = 0; n < 400 && !cmd_ready; n++) @(posedge mclk);
    repeat (3) @(posedge mclk);
    check("burst ended", {31'h0, cmd_ready}, 32'h1);
    check("burst open", {31'h0, bursting}, 32'h0);
    check("memory drive", {31'h0, link.mem_dq_oe}, 32'h0);
  endtask
  // Words trickle in with gaps, so the link must stall mid-burst.
  task automatic wr_burst(input int gap);
    logic [31:0] d [4];
    logic [3:0] ln [4];
    for (int i = 0; i < 4; i++) begin
      d[i] = $urandom;
      ln[i] = 4'($urandom);
    end
    fork
      issue(1'b1);
      for (int i = 0; i <= b; i++) begin
        push(d[i], ln[i]);
        repeat (gap) @(posedge mclk);
      end
    join
    for (int i = 0; i <= b; i++) model[beat_addr(i)] = merge(model[beat_addr(i)], d[i], ln[i]);
    settle();
  endtask
  task automatic rd_burst();
    int k = 0;
    issue(1'b0);
    for (int n = 0; n < 40 && k <= b; n++) begin
      @(posedge mclk);
      if (rd_valid === 1'b1) begin
        check("read word", rd_data, model[beat_addr(k)]);
        k++;
      end
    end
    check("read beats", 32'(k), 32'(b) + 32'h1);
    settle();
  endtask
  // Fill the buffer until it refuses, then drain it with two back-to-back full-word bursts.
  task automatic fill_two(input logic [16:0] blk);
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      push(d, 4'h0);
      model[blk + 17'(i)] = d;
    end
    check("buffer full", {31'h0, wr_ready}, 32'h0);
    a = blk;
    b = 2'h3;
    issue(1'b1);
    a = blk + 17'h4;
    issue(1'b1);
    settle();
  endtask
  task automatic nap();
    sleep_want <= 1'b1;
    repeat (20) @(posedge mclk);
    check("sleep request", {31'h0, sleep_active}, 32'h1);
    check("memory asleep", {31'h0, asleep}, 32'h1);
    sleep_want <= 1'b0;
    repeat (2) @(posedge mclk);
    check("ready in recovery", {31'h0, cmd_ready}, 32'h0);
    a = 17'h00040;
    rd_burst();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset, seed the memory, then random reads and writes in both orders with one sleep.
  initial begin
    void'($urandom(32'h3E9C2251));
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    check("idle bus", link.dq_bus, ssr_pkg::BUS_IDLE);
    il = 1'b1;
    fill_two(17'h00040);
    fill_two(17'h00048);
    for (int i = 0; i < 60; i++) begin
      a = 17'h00040 + 17'($urandom_range(15));
      b = 2'($urandom);
      il = 1'($urandom);
      cfg_interleave <= il;
      repeat (2) @(posedge mclk);
      if ($urandom_range(1)) wr_burst($urandom_range(3));
      else rd_burst();
      if (i == 30) nap();
    end
    test_done();
  end
  // The run needs about 1,000 cycles; forty times that means a hang.
  initial begin
    #400000;
    num_errors++;
    test_done();
  end
endmodule
